//--- trig_qual.sv
// window / interval / signal timeout trigger qualifier
// samples arrive on sys_clk_i from digitizer logic in the same domain, so no synchroniser
`timescale 1ns/1ns
module trig_qual (
  input  wire logic                                sys_clk_i,
  input  wire logic                                rst_n_i,
  input  wire logic                                clk_en_i,
  input  wire logic [4*trig_qual_pkg::SAMPLE_W-1:0] samples_i,
  input  wire trig_qual_pkg::bus_req_t             bus_i,
  output logic [trig_qual_pkg::DATA_W-1:0]          rdata_o,
  output logic                                     trig_o
);
  import trig_qual_pkg::*;

  cfg_t                cfg, next_cfg;
  logic [15:0]         level, next_level;
  logic [CNT_W-1:0]    t_low, next_t_low;
  logic [CNT_W-1:0]    t_high, next_t_high;
  logic [DATA_W-1:0]   next_rdata;
  logic [SAMPLE_W-1:0] src, prev, next_prev;
  logic                prev_valid, next_prev_valid;
  logic [CNT_W-1:0]    cnt, next_cnt;
  logic                armed, next_armed;
  logic                fired, next_fired;
  logic                next_trig;
  logic [SAMPLE_W-1:0] lo_th, hi_th;
  logic [SAMPLE_W:0]   rel_lo, rel_hi;
  logic                up_hi, dn_lo, up_lvl, dn_lvl, start_x, stop_x;
  logic                lim_ok;

  // channel mux; one slice per channel
  logic [SAMPLE_W-1:0] ch [4];
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      assign ch[g] = samples_i[g*SAMPLE_W +: SAMPLE_W];
    end
  endgenerate
  assign src = ch[cfg.channel]; // R1

  // thresholds: relative form saturates at the sample range
  always_comb begin
    rel_lo = {1'b0, level[LVL_A_LSB +: SAMPLE_W]} - {1'b0, level[LVL_B_LSB +: SAMPLE_W]};
    rel_hi = {1'b0, level[LVL_A_LSB +: SAMPLE_W]} + {1'b0, level[LVL_B_LSB +: SAMPLE_W]};
    if (cfg.win_relative) begin
      lo_th = rel_lo[SAMPLE_W] ? '0 : rel_lo[SAMPLE_W-1:0]; // R4
      hi_th = rel_hi[SAMPLE_W] ? '1 : rel_hi[SAMPLE_W-1:0]; // R4
    end else begin
      lo_th = level[LVL_A_LSB +: SAMPLE_W]; // R3
      hi_th = level[LVL_B_LSB +: SAMPLE_W]; // R3
      // a level left over from relative use may sit above the upper one
      if (lo_th > hi_th) lo_th = hi_th; // R5
    end
  end

  // crossings from consecutive samples; single level is the lower field
  always_comb begin
    up_hi  = prev_valid && prev < hi_th && src >= hi_th;             // R18
    dn_lo  = prev_valid && prev > lo_th && src <= lo_th;             // R18
    up_lvl = prev_valid && prev < lo_th && src >= lo_th;
    dn_lvl = prev_valid && prev > lo_th && src <= lo_th;
    start_x = cfg.slope_fall ? dn_lvl : up_lvl;                      // R9
    stop_x  = cfg.timeout_variant_select ? (cfg.slope_fall ? up_lvl : dn_lvl) : start_x; // R16 R15
  end

  // interval limit test on the count at the closing crossing
  always_comb begin
    unique case (cfg.limit)
      LIM_LT:  lim_ok = cnt < t_low;                  // R10
      LIM_GT:  lim_ok = cnt > t_low;                  // R11
      LIM_IN:  lim_ok = cnt > t_low && cnt < t_high;  // R12
      LIM_OUT: lim_ok = cnt < t_low || cnt > t_high;  // R13
    endcase
  end

  // register writes and read data; absolute lower kept at or below upper
  always_comb begin
    next_cfg    = cfg;
    next_level  = level;
    next_t_low  = t_low;
    next_t_high = t_high;
    next_rdata  = '0;
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        CTRL_ADDR: next_cfg = cfg_t'(bus_i.wdata[9:0]); // R14
        LEVEL_ADDR: begin
          next_level = bus_i.wdata[15:0];
          // absolute: lower clamped to upper, it cannot pass it
          if (!next_cfg.win_relative && next_level[LVL_A_LSB +: SAMPLE_W] > next_level[LVL_B_LSB +: SAMPLE_W])
            next_level[LVL_A_LSB +: SAMPLE_W] = next_level[LVL_B_LSB +: SAMPLE_W]; // R5
        end
        TLOW_ADDR:  next_t_low  = bus_i.wdata[CNT_W-1:0];
        THIGH_ADDR: next_t_high = bus_i.wdata[CNT_W-1:0];
        default: ;
      endcase
    end
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        CTRL_ADDR:   next_rdata = {22'h000000, cfg};
        LEVEL_ADDR:  next_rdata = {16'h0000, level};
        TLOW_ADDR:   next_rdata = {8'h00, t_low};
        THIGH_ADDR:  next_rdata = {8'h00, t_high};
        STATUS_ADDR: next_rdata = {7'h00, armed, hi_th, lo_th, src};
        default:     next_rdata = '0;
      endcase
    end
  end

  // qualifier state and trigger pulse
  always_comb begin
    next_prev       = src;
    next_prev_valid = 1'b1;
    next_cnt        = (&cnt) ? cnt : cnt + 1'b1; // R17
    next_armed      = armed;
    next_fired      = fired;
    next_trig       = 1'b0;
    if (!cfg.enable) begin
      next_armed = 1'b0;
      next_fired = 1'b0;
    end else begin
      unique case (cfg.mode)
        MODE_WINDOW: next_trig = up_hi || dn_lo; // R2 R6 R7 R8
        MODE_INTERVAL: begin
          if (start_x) begin
            next_trig  = armed && lim_ok; // R9
            next_armed = 1'b1;
            next_cnt   = '0;              // R17
          end
        end
        MODE_TIMEOUT: begin
          if (armed && !fired && cnt > t_low) begin
            next_trig  = 1'b1; // R15 R16
            next_fired = 1'b1;
          end
          if (armed && stop_x) next_armed = 1'b0;
          if (start_x) begin
            next_armed = 1'b1;
            next_fired = 1'b0;
            next_cnt   = '0; // R17
          end
        end
        default: next_armed = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg        <= cfg_t'(CTRL_RST);
      level      <= LEVEL_RST;
      t_low      <= TIME_RST;
      t_high     <= TIME_RST;
      rdata_o    <= '0;
      prev       <= '0;
      prev_valid <= 1'b0;
      cnt        <= '0; // R17
      armed      <= 1'b0;
      fired      <= 1'b0;
      trig_o     <= 1'b0;
    end else if (clk_en_i) begin
      cfg        <= next_cfg;
      level      <= next_level;
      t_low      <= next_t_low;
      t_high     <= next_t_high;
      rdata_o    <= next_rdata;
      prev       <= next_prev;
      prev_valid <= next_prev_valid;
      cnt        <= next_cnt;
      armed      <= next_armed;
      fired      <= next_fired;
      trig_o     <= next_trig;
    end
  end

  // checks
  a_trig_single_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R18
    clk_en_i && trig_o && cfg.mode == MODE_TIMEOUT |=> !trig_o) else $error("timeout trigger longer than one cycle");
  a_window_cause: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R2
    clk_en_i && cfg.enable && cfg.mode == MODE_WINDOW && (up_hi || dn_lo) |=> trig_o)
    else $error("window crossing gave no trigger");
  a_abs_lower_ok: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R5
    !cfg.win_relative |-> lo_th <= hi_th) else $error("lower threshold above upper");
  a_rel_center: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R4
    cfg.win_relative && !rel_lo[SAMPLE_W] && !rel_hi[SAMPLE_W] |-> hi_th - lo_th == {level[14:8], 1'b0})
    else $error("relative window not symmetric");
  a_cnt_restart: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R17
    clk_en_i && cfg.enable && cfg.mode != MODE_WINDOW && cfg.mode != MODE_OFF && start_x |=> cnt == '0)
    else $error("counter not restarted");
  a_cnt_saturate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R17
    &cnt && !start_x |=> &cnt) else $error("counter wrapped");
  a_interval_lt: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R10
    clk_en_i && cfg.enable && cfg.mode == MODE_INTERVAL && cfg.limit == LIM_LT && armed && start_x && cnt < t_low
    |=> trig_o) else $error("short interval missed");
  a_interval_gt: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R11
    clk_en_i && cfg.enable && cfg.mode == MODE_INTERVAL && cfg.limit == LIM_GT && start_x && cnt <= t_low
    |=> !trig_o) else $error("interval fired too early");
  a_timeout_fire: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R15
    clk_en_i && cfg.enable && cfg.mode == MODE_TIMEOUT && armed && !fired && cnt > t_low |=> trig_o)
    else $error("timeout not reported");
  a_off_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R1
    clk_en_i && !cfg.enable |=> !trig_o) else $error("trigger while disabled");

  // named steps: a running window, a closing interval crossing, a live timeout
  sequence s_win_live;
    clk_en_i && cfg.enable && cfg.mode == MODE_WINDOW;
  endsequence
  sequence s_iv_close;
    clk_en_i && cfg.enable && cfg.mode == MODE_INTERVAL && armed && start_x;
  endsequence
  sequence s_to_live;
    clk_en_i && cfg.enable && cfg.mode == MODE_TIMEOUT && armed && !fired;
  endsequence

  // source routing and threshold forms
  a_src_select: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R1
    src == samples_i[cfg.channel*SAMPLE_W +: SAMPLE_W])
    else $error("wrong source channel");
  a_abs_levels: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R3
    !cfg.win_relative && level[LVL_A_LSB +: SAMPLE_W] <= level[LVL_B_LSB +: SAMPLE_W]
    |-> lo_th == level[LVL_A_LSB +: SAMPLE_W] && hi_th == level[LVL_B_LSB +: SAMPLE_W])
    else $error("absolute levels not taken as set");
  a_rel_shift: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R4
    cfg.win_relative && !rel_lo[SAMPLE_W] && !rel_hi[SAMPLE_W] |-> lo_th + level[15:8] == level[7:0])
    else $error("relative lower not center minus delta");

  // window crossings judged from the raw samples, not the crossing flags
  a_window_rise: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R7
    s_win_live ##0 (prev_valid && prev < hi_th && src >= hi_th) |=> trig_o)
    else $error("upward crossing of upper missed");
  a_window_fall: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R8
    s_win_live ##0 (prev_valid && prev > lo_th && src <= lo_th) |=> trig_o)
    else $error("downward crossing of lower missed");
  a_window_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R6
    s_win_live ##0 (src > lo_th && src < hi_th) |=> !trig_o)
    else $error("trigger inside the window");

  // interval arming on the first crossing, limit conditions at the closing crossing
  a_iv_first_arm: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R9
    clk_en_i && cfg.enable && cfg.mode == MODE_INTERVAL && !armed && start_x |=> armed && !trig_o)
    else $error("first crossing did not only arm");
  a_interval_gt_fire: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R11
    s_iv_close ##0 (cfg.limit == LIM_GT && cnt > t_low) |=> trig_o)
    else $error("long interval missed");
  a_interval_in: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R12
    s_iv_close ##0 (cfg.limit == LIM_IN && cnt > t_low && cnt < t_high) |=> trig_o)
    else $error("in-range interval missed");
  a_interval_in_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R12
    s_iv_close ##0 (cfg.limit == LIM_IN && cnt <= t_low) |=> !trig_o)
    else $error("in-range fired below the band");
  a_interval_out: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R13
    s_iv_close ##0 (cfg.limit == LIM_OUT && (cnt < t_low || cnt > t_high)) |=> trig_o)
    else $error("out-of-range interval missed");

  // timeout variants: edge keeps timing, state stops at the opposite crossing
  a_edge_keep: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R15
    clk_en_i && cfg.enable && cfg.mode == MODE_TIMEOUT && !cfg.timeout_variant_select && armed && !start_x
    |=> armed) else $error("edge timeout dropped its timing");
  a_state_disarm: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R16
    clk_en_i && cfg.enable && cfg.mode == MODE_TIMEOUT && cfg.timeout_variant_select && armed && !start_x
    && (cfg.slope_fall ? up_lvl : dn_lvl) |=> !armed) else $error("state timeout not stopped");
  a_timeout_early: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R15 R16
    s_to_live ##0 (cnt <= t_low) |=> !trig_o)
    else $error("timeout fired early");
  a_fire_once: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R18
    clk_en_i && cfg.enable && cfg.mode == MODE_TIMEOUT && fired && !start_x |=> !trig_o)
    else $error("timeout fired twice");

  // counter steps by one unless restarted or saturated; hazard is a silent wrap or stall
  a_cnt_step: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R17
    clk_en_i && !(&cnt) && !(start_x && cfg.enable && (cfg.mode == MODE_INTERVAL || cfg.mode == MODE_TIMEOUT))
    |=> cnt == $past(cnt) + 24'h000001) else $error("counter did not step");
  // clock enable low freezes state and outputs
  a_freeze: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !clk_en_i |=> trig_o == $past(trig_o) && cnt == $past(cnt))
    else $error("state moved while frozen");
  // read data stand one cycle only
  a_rd_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    clk_en_i && !bus_i.rd |=> rdata_o == '0)
    else $error("read data outside the read cycle");
endmodule // trig_qual

//--- trig_qual_pkg.sv
// trigger qualifier package: types, register map, field layouts, reset values
// assumes 8-bit samples and a 24-bit cycle counter at the sample clock
// Overview of operation
// R1 - one of four channels feeds the qualifier
// R2 - window mode fires crossing high or low
// R3 - absolute type: lower and upper set independently
// R4 - relative type: center minus/plus delta thresholds
// R5 - lower threshold clamped at or below upper
// R6 - full swing triggers on rising and falling
// R7 - upper-only swing triggers on rising only
// R8 - lower-only swing triggers on falling only
// R9 - interval timed between same-direction crossings
// R10 - less-than fires when interval shorter
// R11 - greater-than fires when interval longer
// R12 - in-range fires between lower and upper
// R13 - out-of-range fires outside the band
// R14 - timeout offers edge/state variant, slope, time
// R15 - edge variant: no same slope before timeout
// R16 - state variant: no opposite slope before timeout
// R17 - saturating cycle counter restarts on start crossing
// R18 - consecutive sample compare, one-cycle trigger pulse
package trig_qual_pkg;
  localparam int SAMPLE_W = 8;
  localparam int CNT_W    = 24;
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 32;

  // register offsets
  localparam logic [ADDR_W-1:0] CTRL_ADDR   = 4'h0;
  localparam logic [ADDR_W-1:0] LEVEL_ADDR  = 4'h1;
  localparam logic [ADDR_W-1:0] TLOW_ADDR   = 4'h2;
  localparam logic [ADDR_W-1:0] THIGH_ADDR  = 4'h3;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h4;

  // control field positions
  localparam int CTRL_CH_LSB      = 0;  // 2 bits source channel
  localparam int CTRL_MODE_LSB    = 2;  // 2 bits trigger type
  localparam int CTRL_WIN_REL_BIT = 4;  // relative window type
  localparam int CTRL_SLOPE_BIT   = 5;  // 1 = falling
  localparam int CTRL_LIMIT_LSB   = 6;  // 2 bits limit condition
  localparam int CTRL_VAR_BIT     = 8;  // timeout variant, 1 = state
  localparam int CTRL_EN_BIT      = 9;  // qualifier enable
  // level register: [7:0] lower/center, [15:8] upper/delta
  localparam int LVL_A_LSB = 0;
  localparam int LVL_B_LSB = 8;

  // reset values
  localparam logic [9:0]        CTRL_RST  = 10'h000;
  localparam logic [15:0]       LEVEL_RST = 16'hC040;
  localparam logic [CNT_W-1:0]  TIME_RST  = 24'h000064;

  typedef enum logic [1:0] {MODE_OFF, MODE_WINDOW, MODE_INTERVAL, MODE_TIMEOUT} trig_mode_t;
  typedef enum logic [1:0] {LIM_LT, LIM_GT, LIM_IN, LIM_OUT} limit_t;

  // configuration carried as one struct
  typedef struct packed {
    logic                 enable;
    logic                 timeout_variant_select; // 0 edge, 1 state
    limit_t               limit;
    logic                 slope_fall;
    logic                 win_relative;
    trig_mode_t           mode;
    logic [1:0]           channel;
  } cfg_t;

  // register bus request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;
endpackage

//--- sample_src.sv
// digitized channel source: the bench's waveform on the chosen channel
// assumes the bench sets channel and value just after rising edges
`timescale 1ns/1ns
module sample_src (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [1:0]  chan_i,
  input  wire logic [7:0]  level_i,
  output logic      [31:0] samples_o
);
  logic noise;

  // full-scale toggle each cycle, so a wrong source shows up as crossings
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      noise <= 1'b0;
    end else begin
      noise <= ~noise;
    end
  end

  // unused channels carry the toggling pattern
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      samples_o[8*i +: 8] = (chan_i == 2'(i)) ? level_i : {8{noise}};
    end
  end
endmodule // sample_src

//--- trig_qual_tb_top.sv
// self-checking bench: registers, window, interval and timeout triggering
// assumes trig_qual_pkg, trig_qual and sample_src are compiled first
`timescale 1ns/1ns
module trig_qual_tb_top;
  import trig_qual_pkg::*;
  localparam int TLO = 20;
  localparam int THI = 45;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  bus_req_t    bus = '0;
  logic [1:0]  chan = 2'h0;
  logic [7:0]  level = 8'hD0;
  logic [31:0] samples;
  logic [31:0] rdata;
  logic        trig;
  logic [16:0] rnd = 17'h14B2B;
  int          n_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          cnt = 0;

  always #5 clk = ~clk;

  sample_src src (.sys_clk_i(clk), .rst_n_i(rst_n), .chan_i(chan), .level_i(level), .samples_o(samples));
  trig_qual dut (.sys_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1), .samples_i(samples), .bus_i(bus),
                 .rdata_o(rdata), .trig_o(trig));

  // hang guard, well above the fewer than 1500 cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_errors = n_errors + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk) bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk) bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk) bus <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk) bus <= '0;
    @(negedge clk) d = rdata;
  endtask

  // hold one sample value, counting trigger pulses at mid-cycle
  task automatic seg(input logic [7:0] v, input int n);
    repeat (n) begin
      @(posedge clk) level <= v;
      @(negedge clk) cnt += (trig === 1'b1);
    end
  endtask

  // random source channel picked for every configuration
  task automatic setcfg(input trig_mode_t m, input logic rel, input logic fall, input limit_t l, input logic st);
    rnd = {rnd[15:0], rnd[16] ^ rnd[13]};
    @(posedge clk) bus <= '{1'b1, 1'b0, CTRL_ADDR, {22'h0, cfg_t'{1'b1, st, l, fall, rel, m, rnd[1:0]}}};
    // channel moves on the edge the control word lands, so foreign samples form no crossing
    @(posedge clk) begin
      bus  <= '0;
      chan <= rnd[1:0];
    end
  endtask

  function automatic int iv_exp(limit_t l, int g);
    case (l)
      LIM_LT:  return g < TLO;
      LIM_GT:  return g > TLO;
      LIM_IN:  return g > TLO && g < THI;
      default: return g < TLO || g > THI;
    endcase
  endfunction

  localparam logic [3:0]  RA [5] = '{CTRL_ADDR, LEVEL_ADDR, TLOW_ADDR, THIGH_ADDR, 4'hF};
  localparam logic [31:0] RV [5] = '{32'h0, 32'hC040, 32'h64, 32'h64, 32'h0};
  localparam logic [7:0]  WV [8] = '{8'h20, 8'hD0, 8'h20, 8'h80, 8'hC0, 8'h80, 8'h40, 8'h80};
  localparam logic [15:0] RL [3] = '{16'h2080, 16'h2090, 16'h20F0};
  localparam logic [15:0] RT [3] = '{16'hA060, 16'hB070, 16'hFFD0};

  initial begin
    logic [31:0] d;
    logic [7:0]  lo_v;
    logic [7:0]  hi_v;
    int          g;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(RA[i], d);
      chk("reset value", d, RV[i]);
    end
    // disabled qualifier stays quiet
    seg(8'h20, 4);
    cnt = 0;
    seg(8'hD0, 6);
    chk("disabled", cnt, 0);
    // absolute window, boundary samples included
    setcfg(MODE_WINDOW, 1'b0, 1'b0, LIM_LT, 1'b0);
    for (int i = 0; i < 8; i++) begin
      cnt = 0;
      seg(WV[i], 6);
      chk("window", cnt, {31'h0, ~i[0] | (i == 1)});
    end
    rd(STATUS_ADDR, d);
    chk("source sample", d[23:0], 24'hC04080);
    // relative window moves both thresholds, saturating at full scale
    setcfg(MODE_WINDOW, 1'b1, 1'b0, LIM_LT, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wr(LEVEL_ADDR, {16'h0, RL[i]});
      rd(STATUS_ADDR, d);
      chk("relative", d[23:8], RT[i]);
    end
    setcfg(MODE_WINDOW, 1'b0, 1'b0, LIM_LT, 1'b0);
    wr(LEVEL_ADDR, 32'h50D0);
    rd(STATUS_ADDR, d);
    chk("clamp", d[23:8], 16'h5050);
    // interval: every limit, both slopes, random gaps well off the limits
    wr(LEVEL_ADDR, 32'hC080);
    wr(TLOW_ADDR, 32'(TLO));
    wr(THIGH_ADDR, 32'(THI));
    for (int f = 0; f < 2; f++) begin
      for (int l = 0; l < 4; l++) begin
        setcfg(MODE_INTERVAL, 1'b0, f[0], limit_t'(l), 1'b0);
        lo_v = f[0] ? 8'hF0 : 8'h10;
        hi_v = ~lo_v;
        for (int k = 0; k < 3; k++) begin
          rnd = {rnd[15:0], rnd[16] ^ rnd[13]};
          g = 6 + k * 25 + int'(rnd[2:0]);
          seg(lo_v, 1);
          seg(hi_v, g);
          cnt = 0;
          seg(lo_v, 1);
          seg(hi_v, 4);
          chk("interval", cnt, iv_exp(limit_t'(l), g));
        end
      end
    end
    // timeout: a short gap restarts timing, a fall tells the variants apart
    for (int st = 0; st < 2; st++) begin
      setcfg(MODE_TIMEOUT, 1'b0, 1'b0, LIM_LT, st[0]);
      seg(8'h10, 2);
      cnt = 0;
      seg(8'hF0, 8);
      seg(8'h10, 1);
      seg(8'hF0, 40);
      chk("timeout", cnt, 1);
      cnt = 0;
      seg(8'h10, 1);
      seg(8'hF0, 3);
      seg(8'h10, 40);
      chk("timeout variant", cnt, st[0] ? 0 : 1);
    end
    tally_and_finish();
  end
endmodule // trig_qual_tb_top
